// ==== inc/scss_cfg.svh ====
`ifndef SCSS_CFG_SVH
`define SCSS_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SCSS_OFS_OSC_CTRL 12'h000
`define SCSS_OFS_CONFIG 12'h004
`define SCSS_OFS_STATUS 12'h008

// ----------------------------------------------------------------
// Oscillator control register fields
// ----------------------------------------------------------------
`define SCSS_OSC_SEL_BIT 0
`define SCSS_OSC_TMO_BIT 3
`define SCSS_OSC_FREQ_LSB 4
`define SCSS_OSC_FREQ_MSB 6
`define SCSS_RST_FREQ 3'h6

// ----------------------------------------------------------------
// Configuration word fields
// ----------------------------------------------------------------
`define SCSS_CFG_MODE_LSB 0
`define SCSS_CFG_MODE_MSB 2
`define SCSS_CFG_DUAL_BIT 3
`define SCSS_CFG_PUT_BIT 4
`define SCSS_RST_MODE 3'h2
`define SCSS_RST_DUAL 1'h1
`define SCSS_RST_PUT 1'h1

// ----------------------------------------------------------------
// Oscillator mode encodings
// ----------------------------------------------------------------
`define SCSS_MODE_LOWP 3'h0
`define SCSS_MODE_XTAL 3'h1
`define SCSS_MODE_FAST 3'h2

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SCSS_STAT_STATE_LSB 0
`define SCSS_STAT_STATE_MSB 2
`define SCSS_STAT_RUN_BIT 3
`define SCSS_STAT_EXT_BIT 4
`define SCSS_STAT_CNT_LSB 16
`define SCSS_STAT_CNT_MSB 26

// ----------------------------------------------------------------
// Start-up timer
// ----------------------------------------------------------------
`define SCSS_SUT_W 11
`define SCSS_SUT_CYCLES 11'h400

`endif

// ==== inc/scss_pkg.sv ====
`include "scss_cfg.svh"

package scss_pkg;

	// ----------------------------------------------------------------
	// Clock control states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SCSS_WAIT = 3'h0,
		SCSS_COUNT = 3'h1,
		SCSS_EXT = 3'h3,
		SCSS_SLEEP = 3'h2,
		SCSS_INT = 3'h6
	} scss_state_t;

	// ----------------------------------------------------------------
	// Complete module state apart from the reset synchroniser
	// ----------------------------------------------------------------
	typedef struct packed {
		scss_state_t state;
		logic clkSel;
		logic [2:0] freqSel;
		logic [2:0] oscMode;
		logic dualEn;
		logic putEn;
		logic holdExec;
		logic [`SCSS_SUT_W-1:0] sutCnt;
		logic extS1;
		logic extS2;
		logic extPrev;
		logic intS1;
		logic intS2;
		logic intPrev;
		logic sel;
		logic clkOut;
		logic cpuRun;
		logic tmoStat;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} scss_rec_t;

endpackage : scss_pkg

// ==== design/scss_top.sv ====
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "scss_cfg.svh"


module scss_top (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic extOsc,
	input wire logic internal_oscillator,
	input wire logic pwrtExpired,
	input wire logic sleepReq,
	input wire logic wakeReq,
	input wire logic sysReset,
	output logic sysClkOut,
	output logic extActive,
	output logic cpuRun,
	output logic startTimeoutStatus,
	output logic [2:0] intFreqSel
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic isCrystal(input logic [2:0] mode);
		isCrystal = (mode == `SCSS_MODE_LOWP) || (mode == `SCSS_MODE_XTAL) || (mode == `SCSS_MODE_FAST);
	endfunction : isCrystal

	// Where execution goes when a start-up is launched
	function automatic scss_pkg::scss_state_t startState(input logic selInt, input logic [2:0] mode);
		if (selInt) begin
			startState = scss_pkg::SCSS_INT;
		end else if (isCrystal(mode)) begin
			startState = scss_pkg::SCSS_COUNT;
		end else begin
			startState = scss_pkg::SCSS_EXT;
		end
	endfunction : startState

	function automatic logic addrHit(input logic [11:0] addr);
		addrHit = (addr == `SCSS_OFS_OSC_CTRL) || (addr == `SCSS_OFS_CONFIG) || (addr == `SCSS_OFS_STATUS);
	endfunction : addrHit

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rstSync_r;
	logic rst_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync_r <= 2'h0;
		end else begin
			rstSync_r <= {rstSync_r[0], 1'b1};
		end
	end

	assign rst_n = rstSync_r[1];

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	scss_pkg::scss_rec_t r_r;
	scss_pkg::scss_rec_t r_nxt;
	logic extRise;
	logic wrEn;
	logic wantExt;
	logic srcNow;
	logic srcPrev;
	logic [31:0] rdVal;

	always_comb begin
		r_nxt = r_r;
		// Two-flop sampling of both oscillators
		r_nxt.extS1 = extOsc;
		r_nxt.extS2 = r_r.extS1;
		r_nxt.extPrev = r_r.extS2;
		r_nxt.intS1 = internal_oscillator;
		r_nxt.intS2 = r_r.intS1;
		r_nxt.intPrev = r_r.intS2;
		extRise = r_r.extS2 & ~r_r.extPrev;

		// Bus: zero wait states, answer prepared in the setup cycle
		rdVal = 32'h0;
		unique case (paddr)
			`SCSS_OFS_OSC_CTRL: begin
				rdVal[`SCSS_OSC_SEL_BIT] = r_r.clkSel;
				rdVal[`SCSS_OSC_TMO_BIT] = r_r.tmoStat;
				rdVal[`SCSS_OSC_FREQ_MSB:`SCSS_OSC_FREQ_LSB] = r_r.freqSel;
			end
			`SCSS_OFS_CONFIG: begin
				rdVal[`SCSS_CFG_MODE_MSB:`SCSS_CFG_MODE_LSB] = r_r.oscMode;
				rdVal[`SCSS_CFG_DUAL_BIT] = r_r.dualEn;
				rdVal[`SCSS_CFG_PUT_BIT] = r_r.putEn;
			end
			`SCSS_OFS_STATUS: begin
				rdVal[`SCSS_STAT_STATE_MSB:`SCSS_STAT_STATE_LSB] = r_r.state;
				rdVal[`SCSS_STAT_RUN_BIT] = r_r.cpuRun;
				rdVal[`SCSS_STAT_EXT_BIT] = r_r.sel;
				rdVal[`SCSS_STAT_CNT_MSB:`SCSS_STAT_CNT_LSB] = r_r.sutCnt;
			end
			default: rdVal = 32'h0;
		endcase
		r_nxt.pready = 1'b0;
		r_nxt.pslverr = 1'b0;
		if (psel && !penable) begin
			r_nxt.pready = 1'b1;
			r_nxt.pslverr = !addrHit(paddr);
			r_nxt.prdata = rdVal;
		end
		wrEn = psel && penable && r_r.pready && pwrite && !r_r.pslverr;
		if (wrEn) begin
			if (paddr == `SCSS_OFS_OSC_CTRL) begin
				r_nxt.clkSel = pwdata[`SCSS_OSC_SEL_BIT];
				r_nxt.freqSel = pwdata[`SCSS_OSC_FREQ_MSB:`SCSS_OSC_FREQ_LSB];
			end
			// Configuration only acts at the next start-up
			if (paddr == `SCSS_OFS_CONFIG) begin
				r_nxt.oscMode = pwdata[`SCSS_CFG_MODE_MSB:`SCSS_CFG_MODE_LSB];
				r_nxt.dualEn = pwdata[`SCSS_CFG_DUAL_BIT];
				r_nxt.putEn = pwdata[`SCSS_CFG_PUT_BIT];
			end
		end

		// ----------------------------------------------------------------
		// Source sequencing; the select bit is written here only by a system reset, which clears it
		// ----------------------------------------------------------------
		unique case (r_r.state)
			scss_pkg::SCSS_WAIT: begin
				if (pwrtExpired || !r_r.putEn) begin
					r_nxt.state = startState(r_r.clkSel, r_r.oscMode);
					// Without switchover the timer still runs but execution stalls
					r_nxt.holdExec = !r_r.dualEn;
					r_nxt.sutCnt = '0;
				end
			end
			scss_pkg::SCSS_COUNT: begin
				if (sleepReq) begin
					r_nxt.state = scss_pkg::SCSS_SLEEP;
					r_nxt.sutCnt = '0;
				end else if (r_r.clkSel) begin
					r_nxt.state = scss_pkg::SCSS_INT;
					r_nxt.sutCnt = '0;
				end else if (extRise) begin
					r_nxt.sutCnt = r_r.sutCnt + `SCSS_SUT_W'(1);
					if (r_r.sutCnt == `SCSS_SUT_CYCLES - `SCSS_SUT_W'(1)) begin
						r_nxt.state = scss_pkg::SCSS_EXT;
						r_nxt.holdExec = 1'b0;
					end
				end
			end
			scss_pkg::SCSS_EXT: begin
				if (sleepReq) begin
					r_nxt.state = scss_pkg::SCSS_SLEEP;
				end else if (r_r.clkSel) begin
					r_nxt.state = scss_pkg::SCSS_INT;
				end
			end
			scss_pkg::SCSS_INT: begin
				if (sleepReq) begin
					r_nxt.state = scss_pkg::SCSS_SLEEP;
				end else if (!r_r.clkSel) begin
					// Software switch back: keep running on internal while the timer counts
					r_nxt.state = startState(1'b0, r_r.oscMode);
					r_nxt.holdExec = 1'b0;
					r_nxt.sutCnt = '0;
				end
			end
			scss_pkg::SCSS_SLEEP: begin
				if (wakeReq) begin
					r_nxt.state = startState(r_r.clkSel, r_r.oscMode);
					r_nxt.holdExec = !r_r.dualEn;
					r_nxt.sutCnt = '0;
				end
			end
			default: begin
				r_nxt.state = scss_pkg::SCSS_WAIT;
			end
		endcase

		// Any system reset wins over a simultaneous software write of the clock select bit
		if (sysReset) begin
			r_nxt.clkSel = 1'b0;
			r_nxt.state = scss_pkg::SCSS_WAIT;
			r_nxt.sutCnt = '0;
		end

		r_nxt.tmoStat = (r_nxt.state == scss_pkg::SCSS_EXT);
		r_nxt.cpuRun = (r_nxt.state == scss_pkg::SCSS_EXT) || (r_nxt.state == scss_pkg::SCSS_INT)
			|| ((r_nxt.state == scss_pkg::SCSS_COUNT) && !r_nxt.holdExec);

		// ----------------------------------------------------------------
		// Clock mux
		// ----------------------------------------------------------------
		// Swap only while both sampled sources are low, so the old phase
		// ends whole and the new one starts whole. A dead external source
		// stuck high would block the swap; outside the non-crystal modes the
		// sequencer never asks for it before the timer has seen it toggle.
		// Output must already have been low a cycle, else the low phase shrinks
		wantExt = (r_r.state == scss_pkg::SCSS_EXT);
		if ((wantExt != r_r.sel) && !r_r.extS2 && !r_r.intS2 && !r_r.clkOut) begin
			r_nxt.sel = wantExt;
		end
		srcNow = r_r.sel ? r_r.extS2 : r_r.intS2;
		srcPrev = r_r.sel ? r_r.extPrev : r_r.intPrev;
		if (r_r.state == scss_pkg::SCSS_SLEEP) begin
			// Gate off only once the running high phase has ended
			r_nxt.clkOut = r_r.clkOut && srcNow;
		end else if (!r_r.clkOut && srcPrev) begin
			// Resumed mid-high: wait for a fresh rising edge
			r_nxt.clkOut = 1'b0;
		end else begin
			r_nxt.clkOut = srcNow;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_r.state <= scss_pkg::SCSS_WAIT;
			r_r.clkSel <= 1'b0;
			r_r.freqSel <= `SCSS_RST_FREQ;
			r_r.oscMode <= `SCSS_RST_MODE;
			r_r.dualEn <= `SCSS_RST_DUAL;
			r_r.putEn <= `SCSS_RST_PUT;
			r_r.holdExec <= 1'b0;
			r_r.sutCnt <= '0;
			r_r.extS1 <= 1'b0;
			r_r.extS2 <= 1'b0;
			r_r.extPrev <= 1'b0;
			r_r.intS1 <= 1'b0;
			r_r.intS2 <= 1'b0;
			r_r.intPrev <= 1'b0;
			r_r.sel <= 1'b0;
			r_r.clkOut <= 1'b0;
			r_r.cpuRun <= 1'b0;
			r_r.tmoStat <= 1'b0;
			r_r.prdata <= 32'h0;
			r_r.pready <= 1'b0;
			r_r.pslverr <= 1'b0;
		end else begin
			r_r <= r_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata = r_r.prdata;
	assign pready = r_r.pready;
	assign pslverr = r_r.pslverr;
	assign sysClkOut = r_r.clkOut;
	assign extActive = r_r.sel;
	assign cpuRun = r_r.cpuRun;
	assign startTimeoutStatus = r_r.tmoStat;
	assign intFreqSel = r_r.freqSel;

endmodule : scss_top

// ==== tb/scss_checker.sv ====
`timescale 1ns/1ps
`include "scss_cfg.svh"

module scss_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic sleepReq,
	input wire logic sysReset,
	input wire logic sysClkOut,
	input wire logic extActive,
	input wire logic cpuRun,
	input wire logic startTimeoutStatus,
	input wire logic [2:0] intFreqSel
);
	// ----
	// Port relations
	// ----
	wire logic wrOsc = psel && penable && pwrite && paddr == `SCSS_OFS_OSC_CTRL;
	// Sleep or reset may cut a phase on purpose
	wire logic quiet = !sleepReq && !sysReset;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	chk_ready_setup: assert property (psel && !penable |=> pready) else $error("pready late");
	chk_ready_only: assert property (pready |-> $past(psel) && !$past(penable)) else $error("pready early");
	chk_err_addr: assert property (pslverr |-> pready && !(paddr inside {12'h000, 12'h004, 12'h008}))
		else $error("pslverr wrong");
	chk_freq_write: assert property ($changed(intFreqSel) |-> $past(wrOsc) || $past(wrOsc, 2))
		else $error("freq select changed alone");
	chk_run_status: assert property ($rose(startTimeoutStatus) |-> ##[0:2] cpuRun)
		else $error("no execution at timeout");
	chk_ext_status: assert property ($rose(extActive) |-> ##[0:2] startTimeoutStatus)
		else $error("external without status");
	chk_sleep_abort: assert property (sleepReq && !startTimeoutStatus |=> !startTimeoutStatus [*8])
		else $error("status set after sleep");
	chk_clk_high: assert property ($rose(sysClkOut) && quiet && $past(quiet) ##1 quiet |-> sysClkOut)
		else $error("short high phase");
	chk_clk_low: assert property ($fell(sysClkOut) && quiet && $past(quiet) ##1 quiet |-> !sysClkOut)
		else $error("short low phase");
endmodule : scss_checker

bind scss_top scss_checker u_chk (.*);

// ==== tb/scss_osc_model.sv ====
`timescale 1ns/1ps

module scss_osc_model #(
	parameter real ExtHalf = 176.3,
	parameter real IntHalf = 127.1
) (
	output logic extOsc,
	output logic internal_oscillator
);
	// ----
	// Free-running sources
	// ----
	// Periods unrelated to clk so sync paths see every phase
	initial begin
		extOsc = 1'b0;
		internal_oscillator = 1'b0;
		#17;
		forever #(ExtHalf) extOsc = ~extOsc;
	end
	always #(IntHalf) internal_oscillator = ~internal_oscillator;
endmodule : scss_osc_model

// ==== tb/scss_bench.sv ====
`timescale 1ns/1ps
`include "scss_cfg.svh"

module scss_bench;
	// ----
	// Stimulus and checks
	// ----
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, extOsc, internal_oscillator, sysClkOut, extActive, cpuRun, startTimeoutStatus;
	logic pwrtExpired = 1'b0, sleepReq = 1'b0, wakeReq = 1'b0, sysReset = 1'b0;
	logic [2:0] intFreqSel;
	int bad_count = 0, checks = 0, cycles = 0, extEdges = 0, e0;
	always #25 clk = ~clk;
	always @(posedge extOsc) extEdges++;
	scss_osc_model u_osc (.extOsc(extOsc), .internal_oscillator(internal_oscillator));
	scss_top u_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.extOsc(extOsc), .internal_oscillator(internal_oscillator), .pwrtExpired(pwrtExpired), .sleepReq(sleepReq),
		.wakeReq(wakeReq), .sysReset(sysReset), .sysClkOut(sysClkOut), .extActive(extActive),
		.cpuRun(cpuRun), .startTimeoutStatus(startTimeoutStatus), .intFreqSel(intFreqSel));
	task automatic end_sim;
		$display("Mismatches %0d of %0d checks", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	// Two full timer runs plus a sleep fit well inside this
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q & m, x);
	endtask : rd
	// 0 sleep, 1 wake, 2 system reset
	task automatic pulse(input int k);
		@(posedge clk);
		sleepReq <= (k == 0);
		wakeReq <= (k == 1);
		sysReset <= (k == 2);
		@(posedge clk);
		sleepReq <= 1'b0;
		wakeReq <= 1'b0;
		sysReset <= 1'b0;
	endtask : pulse
	task automatic waitTo(input int t);
		while (extEdges < t) @(posedge clk);
	endtask : waitTo
	task automatic runTimer;
		chk(startTimeoutStatus, 1'b0);
		waitTo(e0 + 1010);
		chk(startTimeoutStatus, 1'b0);
		while (startTimeoutStatus !== 1'b1) @(posedge clk);
		chk(32'(extEdges - e0 >= 1024 && extEdges - e0 <= 1028), 32'h1);
		while (extActive !== 1'b1) @(posedge clk);
		chk(cpuRun, 1'b1);
	endtask : runTimer
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`SCSS_OFS_OSC_CTRL, 32'h79, 32'h60);
		rd(`SCSS_OFS_CONFIG, 32'h1f, 32'h1a);
		rd(`SCSS_OFS_STATUS, 32'h7, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk(q, 32'h0);
		chk(32'(e), 32'h1);
		apb(1'b1, `SCSS_OFS_OSC_CTRL, 32'h08);
		rd(`SCSS_OFS_OSC_CTRL, 32'h79, 32'h00);
		pwrtExpired <= 1'b1;
		e0 = extEdges;
		repeat (4) @(posedge clk);
		chk({cpuRun, extActive}, 2'b10);
		rd(`SCSS_OFS_STATUS, 32'h7, 32'h1);
		runTimer();
		rd(`SCSS_OFS_OSC_CTRL, 32'h79, 32'h08);
		apb(1'b1, `SCSS_OFS_OSC_CTRL, 32'h31);
		rd(`SCSS_OFS_OSC_CTRL, 32'h79, 32'h31);
		chk(intFreqSel, 3'h3);
		while (extActive !== 1'b0) @(posedge clk);
		chk(cpuRun, 1'b1);
		pulse(2);
		e0 = extEdges;
		rd(`SCSS_OFS_OSC_CTRL, 32'h1, 32'h0);
		waitTo(e0 + 200);
		pulse(0);
		waitTo(e0 + 1200);
		chk({startTimeoutStatus, sysClkOut}, 2'b00);
		rd(`SCSS_OFS_STATUS, 32'h7, 32'h2);
		pulse(1);
		e0 = extEdges;
		repeat (4) @(posedge clk);
		runTimer();
		apb(1'b1, `SCSS_OFS_CONFIG, 32'h1b);
		pulse(2);
		e0 = extEdges;
		while (startTimeoutStatus !== 1'b1) @(posedge clk);
		chk(32'(extEdges - e0 < 10), 32'h1);
		rd(`SCSS_OFS_STATUS, 32'h7, 32'h3);
		apb(1'b1, `SCSS_OFS_CONFIG, 32'h12);
		pulse(2);
		repeat (8) @(posedge clk);
		chk({cpuRun, startTimeoutStatus}, 2'b00);
		rd(`SCSS_OFS_STATUS, 32'h7, 32'h1);
		end_sim();
	end
endmodule : scss_bench
